// >>> logic/adcsq_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH

`define ADCSQ_ADDR_W 12
`define ADCSQ_OFF_PINSEL 12'h000
`define ADCSQ_OFF_CTRL 12'h004
`define ADCSQ_OFF_CLKDIV 12'h008
`define ADCSQ_OFF_REF 12'h00C
`define ADCSQ_OFF_RESULT 12'h010

`define ADCSQ_CTRL_START 0
`define ADCSQ_CTRL_BUSY 1
`define ADCSQ_CTRL_PWR 2
`define ADCSQ_CTRL_FLAG 3
`define ADCSQ_CTRL_IE 4

`define ADCSQ_CLKDIV_LSB 0
`define ADCSQ_REF_SEL_LSB 0
`define ADCSQ_REF_VREF_PIN 4
`define ADCSQ_REF_EXT_PIN 5

`define ADCSQ_RST_PINSEL 8'hFF
`define ADCSQ_RST_CLKDIV 3'h0
`define ADCSQ_RST_REF 6'h00

`define ADCSQ_SAMPLE_TICKS 5'h04
`define ADCSQ_CONVERT_TICKS 5'h0C

`endif

// >>> logic/adcsq_pkg.sv
// Types shared by the converter sequencing control
package adcsq_pkg;
    typedef enum logic [1:0] {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_SAMPLE = 2'b01,
        ADCSQ_CONVERT = 2'b11
    } adcsq_state_e;

    typedef enum logic [1:0] {
        ADCSQ_REF_SUPPLY = 2'b00,
        ADCSQ_REF_EXT = 2'b01,
        ADCSQ_REF_BANDGAP = 2'b10
    } adcsq_ref_e;
endpackage

// >>> logic/adcsq_clkdiv.sv
// Power-of-two converter clock divider, one tick per converter clock
`timescale 1ns/1ps
module adcsq_clkdiv #(
    parameter int SEL_W = 3,
    parameter int CNT_W = 7
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic [SEL_W-1:0] sel,
    // Tick out
    output logic tick
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] mask;

    // Code 0 gives a mask of zero, so a tick every cycle
    assign mask = {CNT_W{1'b1}} >> ((CNT_W[SEL_W-1:0]) - sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (clear) begin
            // Preload so the first tick lands one converter clock after start
            cnt <= CNT_W'(1);
            tick <= (mask == '0);
        end else begin
            cnt <= cnt + 1'b1;
            tick <= ((cnt & mask) == mask);
        end
    end
endmodule

// >>> logic/adcsq_top.sv
// Converter sequencing control: pins, reference, clock, start and busy
// What this block does
// - Analog-select bit routes pin to converter and disables its other functions.
// - Analog-selected pin always loses its programmed pull-high resistor.
// - Analog selection overrides the pin's port direction control.
// - Reference comes from supply, external reference pin or bandgap.
// - External reference gets gain one to four, bandgap two to four; supply never.
// - Selected reference is driven on reference output pin when chosen.
// - Start bit low-high-low pulse begins one conversion.
// - Busy flag sets once conversion starts and holds during it.
// - Busy flag clears when conversion completes.
// - Completion sets request flag; interrupt only when enable set.
// - Three-bit divider: 000 no division, each step doubles, 111 is 128.
// - Power enable bit powers converter up, clearing powers it down.
// - Conversion takes four sample then twelve convert clocks, then busy clears.
// - Reference field decode: 0000 supply, 0001-0100 ext, 1010-1100 bandgap.
// - Result is twelve bits, full scale all ones.
`timescale 1ns/1ps
`include "adcsq_map.svh"
module adcsq_top import adcsq_pkg::*; #(
    parameter int PINS = 8,
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADCSQ_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port settings from the I/O block
    input wire logic [PINS-1:0] port_pullup_req,
    input wire logic [PINS-1:0] port_out_en,
    // Pin routing
    output logic [PINS-1:0] pin_analog_en,
    output logic [PINS-1:0] pin_digital_en,
    output logic [PINS-1:0] pin_pullup_en,
    output logic [PINS-1:0] pin_drive_en,
    // Reference selection
    output adcsq_ref_e ref_source,
    output logic [2:0] ref_gain,
    output logic ref_out_pin_en,
    output logic ext_ref_input_pin_en,
    // Analog core
    input wire logic [RES_W-1:0] core_result,
    output logic converter_power_enable,
    output logic core_sample,
    output logic core_convert,
    output logic core_step,
    // Interrupt request
    output logic conv_irq
);
    logic [PINS-1:0] pin_analog_select_reg;
    logic start_bit;
    logic conversion_busy_flag;
    logic irq_flag;
    logic irq_enable;
    logic [2:0] conv_clock_divider_select;
    logic [3:0] ref_source_select;
    logic vref_pin_sel;
    logic ext_pin_sel;
    logic [RES_W-1:0] result;
    adcsq_state_e state;
    logic [4:0] tick_cnt;
    logic tick;
    logic setup;
    logic wr_go;
    logic [31:0] rd_word;
    logic mapped;
    logic wr_ctrl;
    logic start_go;
    logic start_rise;
    logic done;
    logic last_tick;
    adcsq_ref_e next_ref_source;
    logic [2:0] next_ref_gain;

    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready && pwrite;
    assign wr_ctrl = wr_go && (paddr == `ADCSQ_OFF_CTRL);
    assign start_rise = wr_ctrl && !start_bit && pwdata[`ADCSQ_CTRL_START];
    // Falling start bit after a rise ends the pulse
    assign start_go = wr_ctrl && start_bit && !pwdata[`ADCSQ_CTRL_START]
        && converter_power_enable;
    assign last_tick = tick && (state == ADCSQ_CONVERT)
        && (tick_cnt == `ADCSQ_CONVERT_TICKS - 5'h01);
    assign done = last_tick && converter_power_enable && !start_rise;

    // Read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            `ADCSQ_OFF_PINSEL: rd_word[PINS-1:0] = pin_analog_select_reg;
            `ADCSQ_OFF_CTRL: begin
                rd_word[`ADCSQ_CTRL_START] = start_bit;
                rd_word[`ADCSQ_CTRL_BUSY] = conversion_busy_flag;
                rd_word[`ADCSQ_CTRL_PWR] = converter_power_enable;
                rd_word[`ADCSQ_CTRL_FLAG] = irq_flag;
                rd_word[`ADCSQ_CTRL_IE] = irq_enable;
            end
            `ADCSQ_OFF_CLKDIV: rd_word[`ADCSQ_CLKDIV_LSB +: 3] = conv_clock_divider_select;
            `ADCSQ_OFF_REF: begin
                rd_word[`ADCSQ_REF_SEL_LSB +: 4] = ref_source_select;
                rd_word[`ADCSQ_REF_VREF_PIN] = vref_pin_sel;
                rd_word[`ADCSQ_REF_EXT_PIN] = ext_pin_sel;
            end
            `ADCSQ_OFF_RESULT: rd_word[RES_W-1:0] = result;
            default: mapped = 1'b0;
        endcase
    end

    // APB answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_analog_select_reg <= `ADCSQ_RST_PINSEL;
            conv_clock_divider_select <= `ADCSQ_RST_CLKDIV;
            {ext_pin_sel, vref_pin_sel, ref_source_select} <= `ADCSQ_RST_REF;
        end else if (wr_go) begin
            if (paddr == `ADCSQ_OFF_PINSEL) begin
                pin_analog_select_reg <= pwdata[PINS-1:0];
            end
            if (paddr == `ADCSQ_OFF_CLKDIV) begin
                conv_clock_divider_select <= pwdata[`ADCSQ_CLKDIV_LSB +: 3];
            end
            if (paddr == `ADCSQ_OFF_REF) begin
                ref_source_select <= pwdata[`ADCSQ_REF_SEL_LSB +: 4];
                vref_pin_sel <= pwdata[`ADCSQ_REF_VREF_PIN];
                ext_pin_sel <= pwdata[`ADCSQ_REF_EXT_PIN];
            end
        end
    end

    // Control register bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_bit <= 1'b0;
            converter_power_enable <= 1'b0;
            irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            start_bit <= pwdata[`ADCSQ_CTRL_START];
            converter_power_enable <= pwdata[`ADCSQ_CTRL_PWR];
            irq_enable <= pwdata[`ADCSQ_CTRL_IE];
        end
    end

    // Request flag: write one clears, completion wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag <= 1'b0;
        end else if (done) begin
            irq_flag <= 1'b1;
        end else if (wr_ctrl && pwdata[`ADCSQ_CTRL_FLAG]) begin
            irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= (irq_flag || done) && irq_enable;
        end
    end

    // Converter clock divider restarts with each conversion
    adcsq_clkdiv #(
        .SEL_W(3),
        .CNT_W(7)
    ) u_clkdiv (
        .pclk(pclk),
        .presetn(presetn),
        .clear(start_go),
        .sel(conv_clock_divider_select),
        .tick(tick)
    );

    // Conversion sequencer; start rise or power-down aborts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ADCSQ_IDLE;
            tick_cnt <= 5'h00;
        end else if (start_go) begin
            state <= ADCSQ_SAMPLE;
            tick_cnt <= 5'h00;
        end else if (start_rise || !converter_power_enable) begin
            state <= ADCSQ_IDLE;
            tick_cnt <= 5'h00;
        end else if (tick) begin
            unique case (state)
                ADCSQ_IDLE: tick_cnt <= 5'h00;
                ADCSQ_SAMPLE: begin
                    if (tick_cnt == `ADCSQ_SAMPLE_TICKS - 5'h01) begin
                        state <= ADCSQ_CONVERT;
                        tick_cnt <= 5'h00;
                    end else begin
                        tick_cnt <= tick_cnt + 5'h01;
                    end
                end
                ADCSQ_CONVERT: begin
                    if (last_tick) begin
                        state <= ADCSQ_IDLE;
                        tick_cnt <= 5'h00;
                    end else begin
                        tick_cnt <= tick_cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // Busy flag and core strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_busy_flag <= 1'b0;
            core_sample <= 1'b0;
            core_convert <= 1'b0;
            core_step <= 1'b0;
        end else begin
            if (start_go) begin
                conversion_busy_flag <= 1'b1;
            end else if (done || start_rise || !converter_power_enable) begin
                conversion_busy_flag <= 1'b0;
            end
            core_sample <= (state == ADCSQ_SAMPLE);
            core_convert <= (state == ADCSQ_CONVERT);
            core_step <= tick && (state != ADCSQ_IDLE);
        end
    end

    // Result held until the next completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= '0;
        end else if (done) begin
            result <= core_result;
        end
    end

    // Pin routing overrides
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_analog_en <= '0;
            pin_digital_en <= '0;
            pin_pullup_en <= '0;
            pin_drive_en <= '0;
        end else begin
            pin_analog_en <= pin_analog_select_reg;
            pin_digital_en <= ~pin_analog_select_reg;
            pin_pullup_en <= port_pullup_req & ~pin_analog_select_reg;
            pin_drive_en <= port_out_en & ~pin_analog_select_reg;
        end
    end

    // Reference decode
    always_comb begin
        next_ref_source = ADCSQ_REF_SUPPLY;
        next_ref_gain = 3'h1;
        unique case (ref_source_select)
            4'h1, 4'h2, 4'h3, 4'h4: begin
                next_ref_source = ADCSQ_REF_EXT;
                next_ref_gain = ref_source_select[2:0];
            end
            4'hA, 4'hB, 4'hC: begin
                next_ref_source = ADCSQ_REF_BANDGAP;
                next_ref_gain = 3'(ref_source_select - 4'h8);
            end
            default: begin
                next_ref_source = ADCSQ_REF_SUPPLY;
                next_ref_gain = 3'h1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_source <= ADCSQ_REF_SUPPLY;
            ref_gain <= 3'h1;
            ref_out_pin_en <= 1'b0;
            ext_ref_input_pin_en <= 1'b0;
        end else begin
            ref_source <= next_ref_source;
            ref_gain <= next_ref_gain;
            ref_out_pin_en <= vref_pin_sel;
            ext_ref_input_pin_en <= ext_pin_sel;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_sets_busy: assert property (start_go |=> conversion_busy_flag)
        else $error("busy not set after start");
    a_done_clears_busy: assert property (done |=> !conversion_busy_flag)
        else $error("busy not cleared at completion");
    a_done_sets_flag: assert property (done |=> irq_flag && (result == $past(core_result)))
        else $error("flag or result missing at completion");
    a_irq_gated: assert property (conv_irq |-> $past(irq_enable))
        else $error("interrupt raised while disabled");
    a_pullup_dropped: assert property (pin_analog_select_reg[0] |=> !pin_pullup_en[0])
        else $error("pull-high left on analog pin");
    a_dir_override: assert property (##1 (pin_drive_en & $past(pin_analog_select_reg)) == '0)
        else $error("drive left on analog pin");
    a_supply_no_gain: assert property (ref_source == ADCSQ_REF_SUPPLY |-> ref_gain == 3'h1)
        else $error("supply reference amplified");
    a_power_blocks_start: assert property (!converter_power_enable |=> !conversion_busy_flag)
        else $error("busy while powered down");
    a_result_stable: assert property (!done |=> $stable(result))
        else $error("result changed without completion");
    // Busy cycles since the last start, for the length check
    logic [11:0] busy_run;
    logic [11:0] conv_len_exp;

    assign conv_len_exp = (12'h010 << conv_clock_divider_select) - 12'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_run <= 12'h000;
        end else if (start_go) begin
            busy_run <= 12'h000;
        end else if (conversion_busy_flag) begin
            busy_run <= busy_run + 12'h001;
        end
    end

    a_conv_length: assert property (done |-> busy_run == conv_len_exp)
        else $error("conversion not sixteen converter clocks");
    a_ref_ext_gain: assert property (ref_source_select == 4'h3 |=> ref_source == ADCSQ_REF_EXT
        && ref_gain == 3'h3)
        else $error("external gain decode wrong");

    c_conversion_done: cover property (start_go ##[1:300] done);
    c_irq_raised: cover property (done ##1 conv_irq);
    c_abort_rise: cover property (conversion_busy_flag && start_rise);
    c_bandgap_sel: cover property (ref_source == ADCSQ_REF_BANDGAP && ref_gain == 3'h4);
endmodule

// >>> tb/adcsq_core_model.sv
// Behavioural analog converter core feeding the sequencing control
`timescale 1ns/1ps
module adcsq_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the sequencer
    input wire logic converter_power_enable,
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic core_step,
    // Analog level the bench applies, as a code
    input wire logic [11:0] sample_value,
    // Result back to the sequencer
    output logic [11:0] core_result
);
    logic [11:0] held;
    logic tog;

    // Input level is captured only while the sample phase runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 12'h000;
            tog <= 1'b0;
        end else begin
            tog <= ~tog;
            if (converter_power_enable && core_sample) begin
                held <= sample_value;
            end
        end
    end

    // Twelve-bit code; outside a conversion the bus is not trustworthy
    always_comb begin
        if (converter_power_enable && (core_convert || core_step)) begin
            core_result = held;
        end else begin
            core_result = held ^ {12{tog}};
        end
    end
endmodule

// >>> tb/test_adc_sequencing_control.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
`include "adcsq_map.svh"
module test_adc_sequencing_control;
    import adcsq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [`ADCSQ_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] pull_req, out_en, an_en, dig_en, pu_en, drv_en;
    adcsq_ref_e ref_source;
    logic [2:0] ref_gain;
    logic ref_out_en, ext_in_en, pwr, smp, cnv, stp, irq;
    logic [11:0] core_result, sample_value;
    int err_total, checks, phase_cnt, base, i;

    adcsq_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_pullup_req(pull_req),
        .port_out_en(out_en), .pin_analog_en(an_en), .pin_digital_en(dig_en),
        .pin_pullup_en(pu_en), .pin_drive_en(drv_en), .ref_source(ref_source),
        .ref_gain(ref_gain), .ref_out_pin_en(ref_out_en),
        .ext_ref_input_pin_en(ext_in_en), .core_result(core_result),
        .converter_power_enable(pwr), .core_sample(smp), .core_convert(cnv),
        .core_step(stp), .conv_irq(irq));

    adcsq_core_model u_core (.pclk(pclk), .presetn(presetn),
        .converter_power_enable(pwr), .core_sample(smp), .core_convert(cnv),
        .core_step(stp), .sample_value(sample_value), .core_result(core_result));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Cycles spent in sample plus convert phases
    always @(posedge pclk) begin
        if (smp === 1'b1 || cnv === 1'b1) begin
            phase_cnt++;
        end
    end

    task automatic wrap_up;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                wrap_up();
            end
            @(posedge pclk);
        end
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, a > `ADCSQ_OFF_RESULT}, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // One full conversion at divider code sel with the core seeing v
    task automatic convert(input logic [2:0] sel, input logic [11:0] v);
        int n;
        @(posedge pclk);
        sample_value <= v;
        apb(1'b1, `ADCSQ_OFF_CLKDIV, {29'h0, sel}, q);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h0000000D, q);
        base = phase_cnt;
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000004, q);
        apb(1'b0, `ADCSQ_OFF_CTRL, 32'h0, q);
        chk(q & 32'h2, 32'h2, "busy during conversion");
        n = 0;
        while (q[`ADCSQ_CTRL_BUSY] !== 1'b0 && n < 2000) begin
            apb(1'b0, `ADCSQ_OFF_CTRL, 32'h0, q);
            n++;
        end
        chk(q & 32'hA, 32'h8, "busy clear and flag set");
        chk(phase_cnt - base, 32'd16 << sel, "conversion length");
        apb(1'b0, `ADCSQ_OFF_RESULT, 32'h0, q);
        chk(q, {20'h0, v}, "result");
    endtask

    function automatic logic [4:0] ref_exp(input logic [3:0] c);
        if (c >= 4'h1 && c <= 4'h4) return {ADCSQ_REF_EXT, c[2:0]};
        if (c >= 4'hA && c <= 4'hC) return {ADCSQ_REF_BANDGAP, c[2:0] - 3'h0};
        return {ADCSQ_REF_SUPPLY, 3'h1};
    endfunction

    initial begin
        err_total = 0;
        checks = 0;
        phase_cnt = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = '0;
        pwdata = '0;
        pull_req = 8'hFF;
        out_en = 8'hFF;
        sample_value = 12'h000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADCSQ_OFF_PINSEL, 32'h0, q);
        chk(q, 32'h000000FF, "pin select reset");
        apb(1'b0, `ADCSQ_OFF_REF, 32'h0, q);
        chk(q, 32'h0, "reference reset");
        chk({24'h0, pu_en | drv_en | dig_en}, 32'h0, "all pins analog");
        apb(1'b1, `ADCSQ_OFF_PINSEL, 32'h0000000F, q);
        settle(2);
        chk({24'h0, an_en}, 32'h0F, "analog routing");
        chk({24'h0, dig_en}, 32'hF0, "digital functions off");
        chk({24'h0, pu_en}, 32'hF0, "pull-high dropped");
        chk({24'h0, drv_en}, 32'hF0, "direction overridden");
        @(posedge pclk);
        out_en <= 8'h55;
        settle(2);
        chk({24'h0, drv_en}, 32'h50, "direction follows port");
        for (i = 0; i < 16; i++) begin
            apb(1'b1, `ADCSQ_OFF_REF, 32'h30 | i, q);
            settle(2);
            chk({27'h0, ref_source, ref_gain}, {27'h0, ref_exp(4'(i))}, "ref decode");
            chk({30'h0, ref_out_en, ext_in_en}, 32'h3, "ref pins");
        end
        apb(1'b1, `ADCSQ_OFF_REF, 32'h0000000B, q);
        settle(2);
        chk({30'h0, ref_out_en, ext_in_en}, 32'h0, "ref pins off");
        chk({27'h0, ref_source, ref_gain}, 32'h13, "bandgap gain 3");
        apb(1'b0, 12'h014, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        // Start pulse with power off must be ignored
        base = phase_cnt;
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000001, q);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000000, q);
        settle(40);
        apb(1'b0, `ADCSQ_OFF_CTRL, 32'h0, q);
        chk(q & 32'hA, 32'h0, "no conversion unpowered");
        chk(phase_cnt - base, 32'h0, "no phases unpowered");
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000004, q);
        settle(1);
        chk({31'h0, pwr}, 32'h1, "power up");
        settle(20);
        convert(3'h0, 12'hFFF);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000014, q);
        settle(2);
        chk({31'h0, irq}, 32'h1, "irq enabled");
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h0000001C, q);
        settle(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        @(posedge pclk);
        sample_value <= 12'h123;
        settle(10);
        apb(1'b0, `ADCSQ_OFF_RESULT, 32'h0, q);
        chk(q, 32'h00000FFF, "result held");
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000004, q);
        for (i = 1; i < 8; i++) begin
            convert(3'(i), 12'h5A0 + 12'(i));
        end
        // Power removed mid-conversion aborts with no completion
        apb(1'b1, `ADCSQ_OFF_CLKDIV, 32'h00000004, q);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h0000000C, q);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000015, q);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000014, q);
        settle(30);
        apb(1'b1, `ADCSQ_OFF_CTRL, 32'h00000010, q);
        settle(1);
        chk({31'h0, pwr}, 32'h0, "power down");
        settle(3000);
        apb(1'b0, `ADCSQ_OFF_CTRL, 32'h0, q);
        chk(q & 32'hA, 32'h0, "aborted, no flag");
        chk({31'h0, irq}, 32'h0, "no irq after abort");
        wrap_up();
    end

    initial begin
        #(40 * 30000);
        err_total++;
        wrap_up();
    end
endmodule
